/* rtl/ssbp_pkg.sv */
// Shared widths and word layout for the separate-port burst-of-two memory
package ssbp_pkg;
   localparam int DATA_W    = 36;
   localparam int ADDR_W    = 18;
   localparam int LANES     = 4;
   localparam int LANE_W    = 9;
   localparam int NIB_W     = 4;
   localparam int NIB_LANES = 2;
   localparam int WIDE_W    = 2 * DATA_W;
   localparam int WORD0_LSB = 0;
   localparam int WORD1_LSB = DATA_W;
endpackage

/* rtl/ssbp_pin_edge.sv */
// Two-flop synchroniser with rising-edge detect for one outside pin
`timescale 1ns/100ps
module ssbp_pin_edge (
   input  wire logic clock,
   input  wire logic reset,
   input  wire logic pin,
   output logic      level,
   output logic      rise
);
   logic meta_q;
   logic sync_q;
   logic last_q;

   // Chain runs through reset so a pin idling high shows no false edge
   always_ff @(posedge clock) begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
   end

   // Edge taken after the second stage only
   assign level = sync_q;
   assign rise  = sync_q & ~last_q & ~reset;
endmodule

/* rtl/ssbp_port.sv */
// Device-side port logic and storage of the burst-of-two separate-port memory
// Operation
// - Write data sampled on main clock rise and on inverted main clock rise
// - Active-low byte masks sampled on both main clock edges, one per word
// - Deasserted byte mask leaves that stored byte unchanged
// - Mask n governs nine-bit lane n, ascending from bit 0
// - Eight-bit organisation uses two nibble masks for bits 3:0 and 7:4
// - Deasserted nibble mask keeps the stored nibble unchanged
// - Address captured only on main clock rise when an operation starts
// - Read words driven on output clock rise and inverted output clock rise
// - Single clock mode times read data from the main clock pair
// - Read outputs released to high impedance whenever no read is active
// - Load low at main clock rise starts a two-word burst
// - Load high starts nothing but lets bursts in progress finish
// - Loaded select high starts a read, low starts a write
// - Read/write select ignored when load is high
// - Both burst words stored as one wide word in fixed order
`timescale 1ns/100ps
module ssbp_port (
   input  wire logic                       clock,
   input  wire logic                       reset,
   input  wire logic                       k_clock,
   input  wire logic                       k_clock_n,
   input  wire logic                       c_clock,
   input  wire logic                       c_clock_n,
   input  wire logic                       nibble_org,
   input  wire logic                       load_request_n,
   input  wire logic                       read_write,
   input  wire logic [ssbp_pkg::ADDR_W-1:0] shared_addr_in,
   input  wire logic [ssbp_pkg::DATA_W-1:0] write_data_in,
   input  wire logic                       byte_lane_mask0_n,
   input  wire logic                       byte_lane_mask1_n,
   input  wire logic                       byte_lane_mask2_n,
   input  wire logic                       byte_lane_mask3_n,
   input  wire logic                       low_nibble_mask_n,
   input  wire logic                       high_nibble_mask_n,
   output logic [ssbp_pkg::DATA_W-1:0]      read_data_out,
   output logic                            read_data_oe,
   output logic                            echo_clock,
   output logic                            echo_clock_n
);
   localparam int SYNC_W = 3 + ssbp_pkg::ADDR_W + ssbp_pkg::DATA_W
                           + ssbp_pkg::LANES + ssbp_pkg::NIB_LANES;

   // Lane enables for one burst word
   function automatic logic [ssbp_pkg::DATA_W-1:0] lane_en(
      input logic [ssbp_pkg::LANES-1:0]     bw_n,
      input logic [ssbp_pkg::NIB_LANES-1:0] nw_n,
      input logic                           nib);
      logic [ssbp_pkg::DATA_W-1:0] en;
      en = '0;
      for (int l = 0; l < ssbp_pkg::LANES; l++) begin
         en[l*ssbp_pkg::LANE_W +: ssbp_pkg::LANE_W] = {ssbp_pkg::LANE_W{~bw_n[l]}};
      end
      if (nib) begin
         en = '0;
         for (int n = 0; n < ssbp_pkg::NIB_LANES; n++) begin
            en[n*ssbp_pkg::NIB_W +: ssbp_pkg::NIB_W] = {ssbp_pkg::NIB_W{~nw_n[n]}};
         end
      end
      return en;
   endfunction

   function automatic logic [ssbp_pkg::DATA_W-1:0] merge(
      input logic [ssbp_pkg::DATA_W-1:0] old_w,
      input logic [ssbp_pkg::DATA_W-1:0] new_w,
      input logic [ssbp_pkg::DATA_W-1:0] en);
      return (old_w & ~en) | (new_w & en);
   endfunction

   logic                          k_rise, kn_rise;
   logic                          c_lvl, c_rise, cn_lvl, cn_rise;
   logic [SYNC_W-1:0]             pin_meta_q;
   logic [SYNC_W-1:0]             pin_q;
   logic                          nib_s, ld_n_s, rw_s;
   logic [ssbp_pkg::ADDR_W-1:0]   addr_s;
   logic [ssbp_pkg::DATA_W-1:0]   data_s;
   logic [ssbp_pkg::LANES-1:0]    bw_n_s;
   logic [ssbp_pkg::NIB_LANES-1:0] nw_n_s;
   logic [ssbp_pkg::WIDE_W-1:0]   mem [2**ssbp_pkg::ADDR_W];

   ssbp_pin_edge u_k  (.clock(clock), .reset(reset), .pin(k_clock),
                       .level(), .rise(k_rise));
   ssbp_pin_edge u_kn (.clock(clock), .reset(reset), .pin(k_clock_n),
                       .level(), .rise(kn_rise));
   ssbp_pin_edge u_c  (.clock(clock), .reset(reset), .pin(c_clock),
                       .level(c_lvl), .rise(c_rise));
   ssbp_pin_edge u_cn (.clock(clock), .reset(reset), .pin(c_clock_n),
                       .level(cn_lvl), .rise(cn_rise));

   // Same two-flop delay as the clock pins keeps data aligned to the edges
   always_ff @(posedge clock) begin
      if (reset) begin
         pin_meta_q <= '0;
         pin_q      <= '0;
      end else begin
         pin_meta_q <= {nibble_org, load_request_n, read_write, shared_addr_in, write_data_in,
                        byte_lane_mask3_n, byte_lane_mask2_n, byte_lane_mask1_n,
                        byte_lane_mask0_n, high_nibble_mask_n, low_nibble_mask_n};
         pin_q      <= pin_meta_q;
      end
   end

   assign {nib_s, ld_n_s, rw_s, addr_s, data_s, bw_n_s, nw_n_s} = pin_q;

   // Decode of the main clock rise and choice of the output clock edges
   wire start    = k_rise & ~ld_n_s;
   wire start_rd = start & rw_s;
   wire start_wr = start & ~rw_s;
   wire single   = c_lvl & cn_lvl;
   wire o_rise   = single ? k_rise : c_rise;
   wire o_fall   = single ? kn_rise : cn_rise;

   // Write path: address, first word, then second word commits
   logic                          wr_pend_q, wr_hi_q;
   logic [ssbp_pkg::ADDR_W-1:0]   wr_addr_q, wr_cmt_addr_q;
   logic [ssbp_pkg::DATA_W-1:0]   wr_lo_q, wr_en0_q;

   wire [ssbp_pkg::DATA_W-1:0] en_now  = lane_en(bw_n_s, nw_n_s, nib_s);
   wire [ssbp_pkg::WIDE_W-1:0] old_wd  = mem[wr_cmt_addr_q];
   wire                        commit  = kn_rise & wr_hi_q;
   wire [ssbp_pkg::WIDE_W-1:0] new_wd  = {
      merge(old_wd[ssbp_pkg::WORD1_LSB +: ssbp_pkg::DATA_W], data_s, en_now),
      merge(old_wd[ssbp_pkg::WORD0_LSB +: ssbp_pkg::DATA_W], wr_lo_q, wr_en0_q)};

   always_ff @(posedge clock) begin
      if (reset) begin
         wr_pend_q     <= 1'b0;
         wr_hi_q       <= 1'b0;
         wr_addr_q     <= '0;
         wr_cmt_addr_q <= '0;
         wr_lo_q       <= '0;
         wr_en0_q      <= '0;
      end else if (k_rise) begin
         wr_pend_q <= start_wr;
         wr_hi_q   <= wr_pend_q;
         if (start_wr) begin
            wr_addr_q <= addr_s;
         end
         if (wr_pend_q) begin
            wr_cmt_addr_q <= wr_addr_q;
            wr_lo_q       <= data_s;
            wr_en0_q      <= en_now;
         end
      end else if (kn_rise) begin
         wr_hi_q <= 1'b0;
      end
   end

   // No reset on the array; contents are undefined at power-up anyway
   always_ff @(posedge clock) begin
      if (commit) begin
         mem[wr_cmt_addr_q] <= new_wd;
      end
   end

   // Read path: one pending wide word, then two output words
   logic                          rd_pend_v_q, rd_hi_q;
   logic [ssbp_pkg::WIDE_W-1:0]   rd_pend_q;
   logic [ssbp_pkg::DATA_W-1:0]   rd_word1_q;

   always_ff @(posedge clock) begin
      if (reset) begin
         rd_pend_v_q <= 1'b0;
         rd_pend_q   <= '0;
      end else if (start_rd) begin
         rd_pend_v_q <= 1'b1;
         rd_pend_q   <= mem[addr_s];
      end else if (o_rise) begin
         rd_pend_v_q <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         read_data_out <= '0;
         read_data_oe  <= 1'b0;
         rd_hi_q       <= 1'b0;
         rd_word1_q    <= '0;
         echo_clock    <= 1'b0;
         echo_clock_n  <= 1'b1;
      end else if (o_rise) begin
         echo_clock   <= 1'b1;
         echo_clock_n <= 1'b0;
         read_data_oe <= rd_pend_v_q;
         rd_hi_q      <= rd_pend_v_q;
         if (rd_pend_v_q) begin
            read_data_out <= rd_pend_q[ssbp_pkg::WORD0_LSB +: ssbp_pkg::DATA_W];
            rd_word1_q    <= rd_pend_q[ssbp_pkg::WORD1_LSB +: ssbp_pkg::DATA_W];
         end
      end else if (o_fall) begin
         echo_clock   <= 1'b0;
         echo_clock_n <= 1'b1;
         read_data_oe <= rd_hi_q;
         rd_hi_q      <= 1'b0;
         if (rd_hi_q) begin
            read_data_out <= rd_word1_q;
         end
      end
   end

   default clocking dc @(posedge clock); endclocking
   default disable iff (reset);

   AST_OE_ON_OUT_EDGE: assert property ($rose(read_data_oe) |-> $past(o_rise))
      else $error("Read output enabled off an output clock rise");
   AST_OE_NEEDS_READ: assert property (o_rise && !rd_pend_v_q |=> !read_data_oe)
      else $error("Read output driven with no read pending");
   AST_SINGLE_CLOCK: assert property (single && $rose(read_data_oe) |-> $past(k_rise))
      else $error("Single clock mode read not timed by main clock");
   AST_LOAD_HIGH_IDLE: assert property (k_rise && ld_n_s |=> !wr_pend_q)
      else $error("Write started while load was high");
   AST_RW_IGNORED: assert property (k_rise && ld_n_s && rw_s && !rd_pend_v_q |=>
         !rd_pend_v_q)
      else $error("Read started while load was high");
   AST_WRITE_START: assert property (start_wr |=>
         wr_pend_q && wr_addr_q == $past(addr_s))
      else $error("Write load did not capture address");
   AST_READ_START: assert property (start_rd |=> rd_pend_v_q)
      else $error("Read load did not start a read");
   AST_BYTE_KEEP: assert property (commit && !nib_s && bw_n_s[0] |=>
         mem[$past(wr_cmt_addr_q)][ssbp_pkg::WORD1_LSB +: ssbp_pkg::LANE_W]
         == $past(old_wd[ssbp_pkg::WORD1_LSB +: ssbp_pkg::LANE_W]))
      else $error("Masked byte lane was altered");
   AST_NIBBLE_KEEP: assert property (commit && nib_s && nw_n_s[0] |=>
         mem[$past(wr_cmt_addr_q)][ssbp_pkg::WORD1_LSB +: ssbp_pkg::NIB_W]
         == $past(old_wd[ssbp_pkg::WORD1_LSB +: ssbp_pkg::NIB_W]))
      else $error("Masked nibble was altered");
   AST_WORD_ORDER: assert property (commit && &en_now && &wr_en0_q |=>
         mem[$past(wr_cmt_addr_q)] == {$past(data_s), $past(wr_lo_q)})
      else $error("Burst words stored out of order");

   COV_READ:   cover property (start_rd ##[1:200] $rose(read_data_oe));
   COV_WRITE:  cover property (start_wr ##[1:200] commit);
   COV_SINGLE: cover property (single && $rose(read_data_oe));
endmodule

/* sim/ssbp_ctrl.sv */
// Memory controller model driving the link pins of the port
`timescale 1ns/100ps
module ssbp_ctrl (
   input  wire logic                   clock,
   input  wire logic                   single_mode,
   output logic                        k_clock,
   output logic                        k_clock_n,
   output wire logic                   c_clock,
   output wire logic                   c_clock_n,
   output logic                        load_request_n,
   output logic                        read_write,
   output logic [ssbp_pkg::ADDR_W-1:0] shared_addr_in,
   output logic [ssbp_pkg::DATA_W-1:0] write_data_in,
   output logic [5:0]                  mask_n
);
   logic c_q;
   // Both high selects single clock mode
   assign c_clock   = single_mode | c_q;
   assign c_clock_n = single_mode | ~c_q;
   initial begin
      {k_clock, c_q, read_write, shared_addr_in, write_data_in} = '0;
      {k_clock_n, load_request_n, mask_n} = '1;
   end
   task automatic w(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // One main clock cycle of 40 system clocks, at most one load
   task automatic kc(input logic ld, input logic rw, input logic [17:0] a,
         input logic [35:0] d0, input logic [5:0] m0, input logic [35:0] d1,
         input logic [5:0] m1);
      load_request_n = ld;
      read_write = rw;
      shared_addr_in = a;
      write_data_in = d0;
      mask_n = m0;
      w(10);
      {k_clock, k_clock_n} = 2'b10;
      w(5);
      c_q = 1;
      w(5);
      write_data_in = d1;
      mask_n = m1;
      w(10);
      {k_clock, k_clock_n} = 2'b01;
      w(5);
      c_q = 0;
      // Released data must not keep its last value
      write_data_in = ~d1;
      w(5);
   endtask
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the burst-of-two memory port
`timescale 1ns/100ps
module tb_top;
   logic        clock = 0;
   logic        reset = 1;
   logic        nibble_org = 0;
   logic        single_mode = 1;
   logic        k_clock, k_clock_n, c_clock, c_clock_n, load_request_n, read_write;
   logic [17:0] shared_addr_in;
   logic [35:0] write_data_in, read_data_out, o0, o1;
   logic [5:0]  mask_n;
   logic        read_data_oe, echo_clock, echo_clock_n;
   int          failures = 0;
   int          check_count = 0;
   localparam logic [35:0] L02 = 36'h007fc01ff;
   always #2 clock = ~clock;
   ssbp_ctrl i_ssbp_ctrl (.clock(clock), .single_mode(single_mode), .k_clock(k_clock),
      .k_clock_n(k_clock_n), .c_clock(c_clock), .c_clock_n(c_clock_n),
      .load_request_n(load_request_n), .read_write(read_write),
      .shared_addr_in(shared_addr_in), .write_data_in(write_data_in), .mask_n(mask_n));
   ssbp_port i_ssbp_port (.clock(clock), .reset(reset), .k_clock(k_clock),
      .k_clock_n(k_clock_n), .c_clock(c_clock), .c_clock_n(c_clock_n),
      .nibble_org(nibble_org), .load_request_n(load_request_n), .read_write(read_write),
      .shared_addr_in(shared_addr_in), .write_data_in(write_data_in),
      .byte_lane_mask0_n(mask_n[0]), .byte_lane_mask1_n(mask_n[1]),
      .byte_lane_mask2_n(mask_n[2]), .byte_lane_mask3_n(mask_n[3]),
      .low_nibble_mask_n(mask_n[4]), .high_nibble_mask_n(mask_n[5]),
      .read_data_out(read_data_out), .read_data_oe(read_data_oe),
      .echo_clock(echo_clock), .echo_clock_n(echo_clock_n));
   task automatic conclude();
      $display("Checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic cmp_word(input string what, input logic [35:0] e, input logic [35:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic cmp_bit(input string what, input logic e, input logic g);
      cmp_word(what, {35'h0, e}, {35'h0, g});
   endtask
   // Echo marks the output edges; sample two clocks after it settles
   task automatic wait_echo(input logic lvl);
      int n;
      n = 0;
      while (echo_clock !== lvl) begin
         @(posedge clock);
         #1;
         n++;
         if (n > 60) begin
            cmp_bit("echo wait", lvl, echo_clock);
            conclude();
         end
      end
      repeat (2) @(posedge clock);
      #1;
   endtask
   task automatic rd_check(input logic [35:0] care);
      wait_echo(1);
      cmp_bit("read enable", 1'b1, read_data_oe);
      cmp_word("read word0", o0 & care, read_data_out & care);
      cmp_bit("echo pair high", 1'b0, echo_clock_n);
      wait_echo(0);
      cmp_word("read word1", o1 & care, read_data_out & care);
      cmp_bit("echo pair low", 1'b1, echo_clock_n);
   endtask
   // Write burst; the data cycle carries load high with select high
   task automatic s_write(input logic [17:0] a, input logic [35:0] d0, input logic [5:0] m0,
         input logic [35:0] d1, input logic [5:0] m1);
      i_ssbp_ctrl.kc(1'b0, 1'b0, a, ~d0, 6'h00, d0, 6'h00);
      i_ssbp_ctrl.kc(1'b1, 1'b1, ~a, d0, m0, d1, m1);
   endtask
   task automatic s_read(input logic [17:0] a, input logic [35:0] care);
      fork
         i_ssbp_ctrl.kc(1'b0, 1'b1, a, '0, 6'h3f, '1, 6'h3f);
         if (single_mode) begin
            wait_echo(1);
            cmp_bit("stray read", 1'b0, read_data_oe);
         end else rd_check(care);
      join
      fork
         i_ssbp_ctrl.kc(1'b1, 1'b0, ~a, '1, 6'h3f, '0, 6'h3f);
         if (single_mode) rd_check(care);
         else begin
            wait_echo(1);
            cmp_bit("released", 1'b0, read_data_oe);
         end
      join
      if (single_mode) fork
         i_ssbp_ctrl.kc(1'b1, 1'b1, a, '0, 6'h3f, '1, 6'h3f);
         begin
            wait_echo(1);
            cmp_bit("released", 1'b0, read_data_oe);
         end
      join
   endtask
   initial begin
      repeat (6) @(posedge clock);
      #1;
      reset = 0;
      cmp_bit("enable at reset", 1'b0, read_data_oe);
      repeat (3) @(posedge clock);
      #1;
      o0 = 36'h123456789;
      o1 = 36'hfedcba987;
      s_write(18'h00005, o0, 6'h00, o1, 6'h00);
      s_read(18'h00005, '1);
      // Alternate lanes per word: 0 and 2 first, then 1 and 3
      s_write(18'h00005, 36'h111111111, 6'h3a, 36'h222222222, 6'h35);
      o0 = (36'h111111111 & L02) | (o0 & ~L02);
      o1 = (36'h222222222 & ~L02) | (o1 & L02);
      s_read(18'h00005, '1);
      nibble_org = 1;
      s_write(18'h00005, 36'h0000000ab, 6'h2f, 36'h0000000cd, 6'h1f);
      o0[3:0] = 4'hb;
      o1[7:4] = 4'hc;
      s_read(18'h00005, 36'h0000000ff);
      single_mode = 0;
      repeat (5) i_ssbp_ctrl.kc(1'b1, 1'b0, '0, '0, 6'h3f, '0, 6'h3f);
      s_read(18'h00005, 36'h0000000ff);
      conclude();
   end
endmodule
